// ==== tpc_cfg.svh ====
// Register map, field positions and counts for the transport packet capture channel
// Summary of operation
// [R01] Byte-wide input bus is sampled at each rising edge of the capture clock.
// [R02] Bytes are valid and stored only while capture valid is active.
// [R03] Packet start with capture valid begins a packet; first byte may hold any value.
// [R04] Once begun, every valid byte is stored until size is reached; starts never restart.
// [R05] 24-bit byte counter, read as two fields, ends the packet when equal to size.
// [R06] Packet size is the low 12-bit field joined under the high 12-bit field.
// [R07] Stored packet holds the marker byte and all payload bytes, none discarded.
// [R08] After a packet the channel idles until the next active packet start.
// [R09] Bytes are packed into 64-bit words before each capture FIFO write.
// [R10] With filtering on, an error in the first eight bytes drops data until next start.
// [R11] Otherwise the packet is kept whole and its timestamp carries the packet error flag.
// [R12] An early start still captures full size and sets the timestamp early start flag.
// [R13] The system must toggle the system time clock whenever this mode is used.
// [R14] Extension counter runs 0 to 299 on system time clock; each wrap bumps 33-bit base.
// [R15] With counter mode bit set, base counts every system clock; extension unused.
// [R16] System time is snapshot at each first byte and written after that packet's data.
// [R17] Software may load the system time counter, and reload it at any later time.
// [R18] Current system time is readable at any time through two registers.
// [R19] An event is raised at a programmed system time or after a programmed cycle count.
// [R20] Continuous mode: capture repeatedly, set completion flag each packet, ignore it.
// [R21] Noncontinuous: set flag each packet; halt after the next packet unless cleared.
// [R22] Single mode: set flag and capture nothing until cleared; both bits set is reserved.
// [R23] A DMA request is raised each time the programmed word threshold has accumulated.
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_ADDR_W          8
`define TPC_ADDR_CTRL       8'h00
`define TPC_ADDR_SIZE       8'h04
`define TPC_ADDR_STATUS     8'h08
`define TPC_ADDR_THRESH     8'h0C
`define TPC_ADDR_STIME_LO   8'h10
`define TPC_ADDR_STIME_HI   8'h14
`define TPC_ADDR_ALARM_LO   8'h18
`define TPC_ADDR_ALARM_HI   8'h1C
`define TPC_ADDR_CYCLE      8'h20

`define TPC_CTRL_EN         0
`define TPC_CTRL_CONT       1
`define TPC_CTRL_SINGLE     2
`define TPC_CTRL_FILT       3
`define TPC_CTRL_CNTMODE    4
`define TPC_CTRL_ABS_EN     5
`define TPC_CTRL_CYC_EN     6

`define TPC_STAT_DONE       28
`define TPC_STAT_CMPL       29
`define TPC_STAT_ALARM      30

`define TPC_HI_EXT_LSB      16
`define TPC_SIZE_HI_LSB     16

`define TPC_EXT_LAST        9'h12B
`define TPC_FILTER_BYTES    24'h000008
`define TPC_FLAG_PACKET_ERROR_FLAG       63
`define TPC_FLAG_EARLY      62

`endif

// ==== tpc_pkg.sv ====
// Types shared by the transport packet capture channel
package tpc_pkg;
   typedef enum logic [1:0] {
      TPC_IDLE,
      TPC_CAPTURE,
      TPC_DROP
   } tpc_state_t;
endpackage

// ==== tpc_stc.sv ====
// System time counter: 33-bit base with 9-bit extension, loadable
`timescale 1ns/100ps
`include "tpc_cfg.svh"
module tpc_stc #(
   parameter int BASE_W = 33,
   parameter int EXT_W  = 9
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              tick,
   input  wire logic              counter_mode_bit,
   input  wire logic              load,
   input  wire logic [BASE_W-1:0] load_base,
   input  wire logic [EXT_W-1:0]  load_ext,
   output logic      [BASE_W-1:0] base,
   output logic      [EXT_W-1:0]  ext
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base <= '0;
         ext  <= '0;
      end else if (load) begin // [R17]
         base <= load_base;
         ext  <= counter_mode_bit ? '0 : load_ext;
      end else if (tick) begin
         if (counter_mode_bit) begin // [R15]
            base <= base + 1'b1;
            ext  <= '0;
         end else if (ext == EXT_W'(`TPC_EXT_LAST)) begin // [R14]
            ext  <= '0;
            base <= base + 1'b1;
         end else begin
            ext <= ext + 1'b1;
         end
      end
   end
endmodule

// ==== tpc_capture.sv ====
// Transport packet capture channel with APB registers and system time stamping
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "tpc_cfg.svh"
module tpc_capture
   import tpc_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter int THR_W = 16
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`TPC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  capture_clock_in,
   input  wire logic [7:0]            capture_data_in,
   input  wire logic                  packet_start_in,
   input  wire logic                  capture_valid_in,
   input  wire logic                  packet_error_in,
   input  wire logic                  system_time_clock_in,
   output logic                       fifo_wr_valid,
   output logic      [63:0]           fifo_wr_data,
   output logic                       dma_request,
   output logic                       time_event
);
   // Pin synchroniser bit positions
   localparam int SY_ERR = 8;
   localparam int SY_VAL = 9;
   localparam int SY_STA = 10;
   localparam int SY_CCK = 11;
   localparam int SY_SCK = 12;

   logic [12:0]      sync1;
   logic [12:0]      sync2;
   logic             cap_clk_d;
   logic             st_clk_d;
   logic             byte_take;
   logic             st_tick;

   logic             capture_channel_enable;
   logic             continuous_mode;
   logic             single_mode;
   logic             error_filter_enable;
   logic             counter_mode_bit;
   logic             abs_alarm_en;
   logic             cyc_alarm_en;
   logic [11:0]      size_low_field;
   logic [11:0]      size_high_field;
   logic [THR_W-1:0] dma_threshold_field;
   logic [31:0]      load_low;
   logic [32:0]      alarm_base;
   logic [8:0]       alarm_ext;
   logic [31:0]      cycle_interval;
   logic             completion_flag;
   logic             capture_complete_status;
   logic             alarm_flag;

   tpc_state_t       state;
   logic [CNT_W-1:0] count;
   logic [63:0]      pack;
   logic             packet_error_flag;
   logic             early;
   logic [32:0]      ts_base;
   logic [8:0]       ts_ext;
   logic [63:0]      ts_word;
   logic             ts_pending;
   logic             packet_done;
   logic             halt_pending;
   logic [THR_W-1:0] word_count;
   logic [31:0]      cycle_count;
   logic             time_match_d;

   logic [32:0]      stc_base;
   logic [8:0]       stc_ext;
   logic             stc_load;

   logic             apb_write;
   logic             apb_setup_read;
   logic             addr_ok;
   logic [31:0]      next_rdata;

   logic             allowed;
   logic             take_start;
   logic             take_cont;
   logic             accept;
   logic             drop;
   logic [CNT_W-1:0] base_count;
   logic [CNT_W-1:0] new_count;
   logic [63:0]      byte_word;
   logic             last;
   logic             emit;
   logic             next_packet_error_flag;
   logic             next_early;
   logic [CNT_W-1:0] packet_size_limit;
   logic             eff_cont;
   logic             time_match;

   // Two stages before any logic looks at a pin; clock edges found on stage two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1     <= 13'h0000;
         sync2     <= 13'h0000;
         cap_clk_d <= 1'b0;
         st_clk_d  <= 1'b0;
      end else begin
         sync1     <= {system_time_clock_in, capture_clock_in, packet_start_in,
                       capture_valid_in, packet_error_in, capture_data_in};
         sync2     <= sync1;
         cap_clk_d <= sync2[SY_CCK];
         st_clk_d  <= sync2[SY_SCK];
      end
   end

   // Data travels with the clock through the same stages, so it stays aligned
   assign byte_take = sync2[SY_CCK] & ~cap_clk_d & sync2[SY_VAL]; // [R01] [R02]
   assign st_tick   = sync2[SY_SCK] & ~st_clk_d; // [R13]

   // APB slave: zero wait states, read data registered in the setup cycle
   assign apb_write      = psel & penable & pwrite;
   assign apb_setup_read = psel & ~penable & ~pwrite;
   assign pready         = 1'b1;
   assign pslverr        = psel & penable & ~addr_ok;

   always_comb begin
      addr_ok    = 1'b1;
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         `TPC_ADDR_CTRL:     next_rdata = {25'h0, cyc_alarm_en, abs_alarm_en, counter_mode_bit,
                                           error_filter_enable, single_mode, continuous_mode,
                                           capture_channel_enable};
         `TPC_ADDR_SIZE:     next_rdata = {4'h0, size_high_field, 4'h0, size_low_field};
         `TPC_ADDR_STATUS:   next_rdata = {1'b0, alarm_flag, capture_complete_status, completion_flag,
                                           count[23:12], 4'h0, count[11:0]}; // [R05]
         `TPC_ADDR_THRESH:   next_rdata = {{(32-THR_W){1'b0}}, dma_threshold_field};
         `TPC_ADDR_STIME_LO: next_rdata = stc_base[31:0]; // [R18]
         `TPC_ADDR_STIME_HI: next_rdata = {7'h00, stc_ext, 15'h0000, stc_base[32]}; // [R18]
         `TPC_ADDR_ALARM_LO: next_rdata = alarm_base[31:0];
         `TPC_ADDR_ALARM_HI: next_rdata = {7'h00, alarm_ext, 15'h0000, alarm_base[32]};
         `TPC_ADDR_CYCLE:    next_rdata = cycle_interval;
         default:            addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup_read) begin
         prdata <= next_rdata;
      end
   end

   // Control and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_channel_enable <= 1'b0;
         continuous_mode        <= 1'b0;
         single_mode            <= 1'b0;
         error_filter_enable    <= 1'b0;
         counter_mode_bit       <= 1'b0;
         abs_alarm_en           <= 1'b0;
         cyc_alarm_en           <= 1'b0;
         size_low_field         <= 12'h000;
         size_high_field        <= 12'h000;
         dma_threshold_field    <= '0;
         load_low               <= 32'h0000_0000;
         alarm_base             <= 33'h0_0000_0000;
         alarm_ext              <= 9'h000;
         cycle_interval         <= 32'h0000_0000;
      end else if (apb_write) begin
         unique case (paddr)
            `TPC_ADDR_CTRL: begin
               capture_channel_enable <= pwdata[`TPC_CTRL_EN];
               continuous_mode        <= pwdata[`TPC_CTRL_CONT];
               single_mode            <= pwdata[`TPC_CTRL_SINGLE];
               error_filter_enable    <= pwdata[`TPC_CTRL_FILT];
               counter_mode_bit       <= pwdata[`TPC_CTRL_CNTMODE];
               abs_alarm_en           <= pwdata[`TPC_CTRL_ABS_EN];
               cyc_alarm_en           <= pwdata[`TPC_CTRL_CYC_EN];
            end
            `TPC_ADDR_SIZE: begin
               size_low_field  <= pwdata[11:0];
               size_high_field <= pwdata[`TPC_SIZE_HI_LSB +: 12];
            end
            `TPC_ADDR_THRESH:   dma_threshold_field <= pwdata[THR_W-1:0];
            `TPC_ADDR_STIME_LO: load_low <= pwdata;
            `TPC_ADDR_ALARM_LO: alarm_base[31:0] <= pwdata;
            `TPC_ADDR_ALARM_HI: begin
               alarm_base[32] <= pwdata[0];
               alarm_ext      <= pwdata[`TPC_HI_EXT_LSB +: 9];
            end
            `TPC_ADDR_CYCLE:    cycle_interval <= pwdata;
            default: begin
            end
         endcase
      end
   end

   // Writing the high half commits the whole load, so a reload is never torn
   assign stc_load = apb_write & (paddr == `TPC_ADDR_STIME_HI); // [R17]

   tpc_stc #(
      .BASE_W (33),
      .EXT_W  (9)
   ) u_stc (
      .pclk             (pclk),
      .presetn          (presetn),
      .tick             (st_tick),
      .counter_mode_bit (counter_mode_bit),
      .load             (stc_load),
      .load_base        ({pwdata[0], load_low}),
      .load_ext         (pwdata[`TPC_HI_EXT_LSB +: 9]),
      .base             (stc_base),
      .ext              (stc_ext)
   );

   // Capture decision for the byte on hand
   assign packet_size_limit = {size_high_field, size_low_field}; // [R06]
   assign eff_cont = continuous_mode & ~single_mode; // Reserved pair acts as single
   assign allowed  = capture_channel_enable & ~halt_pending & ~(single_mode & completion_flag); // [R22] [R21]

   always_comb begin
      take_start = byte_take & sync2[SY_STA] & allowed & (state != TPC_CAPTURE); // [R03] [R08]
      take_cont  = byte_take & (state == TPC_CAPTURE); // [R04]
      accept     = take_start | take_cont;
      base_count = (state == TPC_CAPTURE) ? count : '0;
      new_count  = base_count + 1'b1;
      byte_word  = ((state == TPC_CAPTURE) ? pack : 64'h0) |
                   (64'(sync2[7:0]) << {base_count[2:0], 3'b000}); // [R07]
      last       = (new_count == packet_size_limit); // [R05]
      emit       = last | (base_count[2:0] == 3'h7); // [R09]
      drop       = accept & error_filter_enable & sync2[SY_ERR] &
                   (base_count < CNT_W'(`TPC_FILTER_BYTES)); // [R10]
      next_packet_error_flag  = ((state == TPC_CAPTURE) & packet_error_flag) | sync2[SY_ERR]; // [R11]
      next_early = (state == TPC_CAPTURE) & (early | sync2[SY_STA]); // [R12]
   end

   // Packet state, packing and FIFO writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= TPC_IDLE;
         count         <= '0;
         pack          <= 64'h0;
         packet_error_flag          <= 1'b0;
         early         <= 1'b0;
         ts_base       <= 33'h0_0000_0000;
         ts_ext        <= 9'h000;
         ts_word       <= 64'h0;
         ts_pending    <= 1'b0;
         packet_done   <= 1'b0;
         fifo_wr_valid <= 1'b0;
         fifo_wr_data  <= 64'h0;
      end else begin
         fifo_wr_valid <= 1'b0;
         packet_done   <= 1'b0;
         // Byte edges are several cycles apart, so the stamp never meets a data word
         if (ts_pending) begin
            fifo_wr_valid <= 1'b1;
            fifo_wr_data  <= ts_word; // [R16]
            ts_pending    <= 1'b0;
         end
         if (take_start) begin
            ts_base <= stc_base; // [R16]
            ts_ext  <= stc_ext;
         end
         if (drop) begin
            // The error falls within the first word, so nothing has reached the FIFO yet; the partial word is lost
            state <= TPC_DROP; // [R10]
            pack  <= 64'h0;
            count <= '0;
         end else if (accept) begin
            count <= new_count;
            packet_error_flag  <= next_packet_error_flag;
            early <= next_early;
            if (emit) begin
               fifo_wr_valid <= 1'b1;
               fifo_wr_data  <= byte_word; // [R09]
               pack          <= 64'h0;
            end else begin
               pack <= byte_word;
            end
            if (last) begin
               state       <= TPC_IDLE; // [R08]
               packet_done <= 1'b1;
               ts_pending  <= 1'b1;
               ts_word     <= {next_packet_error_flag, next_early, 20'h00000,
                               take_start ? stc_ext : ts_ext,
                               take_start ? stc_base : ts_base}; // [R11] [R12]
            end else begin
               state <= TPC_CAPTURE;
            end
         end
      end
   end

   // Completion flag and halt control; a new completion wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         completion_flag         <= 1'b0;
         capture_complete_status <= 1'b0;
         halt_pending            <= 1'b0;
      end else begin
         if (packet_done) begin
            completion_flag         <= 1'b1; // [R20] [R21] [R22]
            capture_complete_status <= 1'b1; // [R20]
         end else if (apb_write && paddr == `TPC_ADDR_STATUS) begin
            if (pwdata[`TPC_STAT_DONE]) begin
               completion_flag <= 1'b0;
            end
            if (pwdata[`TPC_STAT_CMPL]) begin
               capture_complete_status <= 1'b0;
            end
         end
         if (packet_done && !eff_cont && !single_mode && completion_flag) begin
            halt_pending <= 1'b1; // [R21]
         end else if (!completion_flag || eff_cont) begin
            halt_pending <= 1'b0; // [R20]
         end
      end
   end

   // DMA request once per threshold of 64-bit words written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_count  <= '0;
         dma_request <= 1'b0;
      end else begin
         dma_request <= 1'b0;
         if (fifo_wr_valid && dma_threshold_field != '0) begin
            if (word_count + 1'b1 == dma_threshold_field) begin
               word_count  <= '0;
               dma_request <= 1'b1; // [R23]
            end else begin
               word_count <= word_count + 1'b1;
            end
         end
      end
   end

   // Time events: absolute match on counter change, or interval of system clocks
   assign time_match = ({stc_base, stc_ext} == {alarm_base, alarm_ext});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_count  <= 32'h0000_0000;
         time_match_d <= 1'b0;
         alarm_flag   <= 1'b0;
      end else begin
         time_match_d <= time_match;
         if (!cyc_alarm_en) begin
            cycle_count <= 32'h0000_0000;
         end else if (st_tick) begin
            cycle_count <= (cycle_count + 1'b1 == cycle_interval) ? 32'h0000_0000 : cycle_count + 1'b1;
         end
         if ((abs_alarm_en && time_match && !time_match_d) ||
             (cyc_alarm_en && st_tick && cycle_interval != 32'h0000_0000 &&
              cycle_count + 1'b1 == cycle_interval)) begin
            alarm_flag <= 1'b1; // [R19]
         end else if (apb_write && paddr == `TPC_ADDR_STATUS && pwdata[`TPC_STAT_ALARM]) begin
            alarm_flag <= 1'b0;
         end
      end
   end
   assign time_event = alarm_flag;
endmodule

// ==== tpc_capture_checker.sv ====
// Port-level assertions for the transport packet capture channel
`timescale 1ns/100ps
module tpc_capture_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fifo_wr_valid,
   input wire logic [63:0] fifo_wr_data,
   input wire logic        dma_request,
   input wire logic        time_event
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   logic ev_clr;
   assign mapped = (paddr <= 8'h20) && (paddr[1:0] == 2'h0);
   assign ev_clr = psel && penable && pwrite && (paddr == 8'h08) && pwdata[30];
   ready_high_a: assert property (pready)
      else $error("pready low");
   slverr_map_a: assert property (pslverr == (psel && penable && !mapped))
      else $error("pslverr does not match address map");
   unmap_zero_a: assert property (psel && !penable && !pwrite && !mapped |=> prdata == 32'h0)
      else $error("unmapped read data not zero");
   rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");
   dma_pulse_a: assert property (dma_request |-> $past(fifo_wr_valid) ##1 !dma_request)
      else $error("dma request not a pulse after a write");
   two_words_a: assert property (fifo_wr_valid ##1 fifo_wr_valid |=> !fifo_wr_valid)
      else $error("more than data plus stamp back to back");
   stamp_fmt_a: assert property (fifo_wr_valid ##1 fifo_wr_valid |-> fifo_wr_data[61:42] == 20'h0
      && fifo_wr_data[41:33] <= 9'h12B)
      else $error("timestamp word malformed");
   event_hold_a: assert property (time_event && !ev_clr |=> time_event)
      else $error("time event dropped without clear");
endmodule
bind tpc_capture tpc_capture_checker tpc_capture_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_wr_valid, .fifo_wr_data, .dma_request, .time_event);

// ==== tpc_source.sv ====
// Front-end source model: transport byte stream and system time clock
`timescale 1ns/100ps
module tpc_source (
   output logic       capture_clock_in,
   output logic [7:0] capture_data_in,
   output logic       packet_start_in,
   output logic       capture_valid_in,
   output logic       packet_error_in,
   output logic       system_time_clock_in
);
   initial begin
      capture_clock_in = 1'b0;
      capture_data_in = 8'h00;
      packet_start_in = 1'b0;
      capture_valid_in = 1'b0;
      packet_error_in = 1'b0;
      system_time_clock_in = 1'b0;
   end
   // Free-running oscillator, unrelated to the byte clock
   always #24 system_time_clock_in = ~system_time_clock_in;
   // Byte clock only runs inside a burst; lines change on its falling edge
   task automatic send(input int n, input int s0, input int s2, input int er, input logic [7:0] b0);
      for (int k = 0; k < n; k++) begin
         capture_data_in = b0 + k[7:0];
         packet_start_in = (k == s0) || (k == s2);
         capture_valid_in = 1'b1;
         packet_error_in = (k == er);
         #40 capture_clock_in = 1'b1;
         #40 capture_clock_in = 1'b0;
      end
      capture_valid_in = 1'b0;
      packet_start_in = 1'b0;
      packet_error_in = 1'b0;
      capture_data_in = ~capture_data_in;
   endtask
endmodule

// ==== tpc_capture_tb.sv ====
// Self-checking bench for the transport packet capture channel
`timescale 1ns/100ps
`include "tpc_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
$display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tpc_capture_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic [7:0]  paddr, capture_data_in;
   logic [31:0] pwdata, prdata, rd;
   logic        capture_clock_in, packet_start_in, capture_valid_in, packet_error_in;
   logic        system_time_clock_in, fifo_wr_valid, dma_request, time_event;
   logic [63:0] fifo_wr_data;
   logic [63:0] q[$];
   int          errors, total_checks, dmas;
   tpc_capture tpc_capture_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .capture_clock_in, .capture_data_in, .packet_start_in, .capture_valid_in,
      .packet_error_in, .system_time_clock_in, .fifo_wr_valid, .fifo_wr_data, .dma_request, .time_event);
   tpc_source tpc_source_i (.capture_clock_in, .capture_data_in, .packet_start_in, .capture_valid_in,
      .packet_error_in, .system_time_clock_in);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (fifo_wr_valid === 1'b1) q.push_back(fifo_wr_data);
      if (dma_request === 1'b1) dmas++;
   end
   // Waits an edge first so two calls never touch psel in one time step
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pkt(input int n, s0, s2, er, input logic [7:0] b0, input logic [1:0] fl, input int nw);
      q = {};
      tpc_source_i.send(n, s0, s2, er, b0);
      repeat (20) @(posedge pclk);
      `CHK(q.size(), nw)
      if (nw > 0) begin
         for (int k = 0; k < 8 * (nw - 1); k++)
            `CHK(q[k/8][8*(k%8)+:8], (k < n) ? b0 + k[7:0] : 8'h00)
         `CHK(q[nw-1][63:62], fl)
      end
   endtask
   task automatic t_basic;
      bus(1'b0, 8'h40, 32'h0);
      `CHK({se, rd}, 33'h1_0000_0000)
      bus(1'b1, `TPC_ADDR_SIZE, 32'h0ABC_0123);
      bus(1'b0, `TPC_ADDR_SIZE, 32'h0);
      `CHK(rd, 32'h0ABC_0123)
      bus(1'b1, `TPC_ADDR_SIZE, 32'h0000_000A);
      bus(1'b1, `TPC_ADDR_THRESH, 32'h3);
      bus(1'b1, `TPC_ADDR_CTRL, 32'h3);
      dmas = 0;
      pkt(2, -1, -1, -1, 8'h10, 2'b00, 0);
      pkt(10, 0, -1, -1, 8'h47, 2'b00, 3);
      `CHK(dmas, 1)
      bus(1'b0, `TPC_ADDR_STATUS, 32'h0);
      `CHK(rd[11:0], 12'h00A)
      `CHK(rd[29:28], 2'b11)
      pkt(3, -1, -1, -1, 8'h55, 2'b00, 0);
      pkt(10, 0, -1, -1, 8'hA0, 2'b00, 3);
      $display("test basic done");
   endtask
   task automatic t_err;
      bus(1'b1, `TPC_ADDR_CTRL, 32'hB);
      pkt(10, 0, -1, 3, 8'h20, 2'b00, 0);
      pkt(10, 0, -1, 8, 8'h30, 2'b10, 3);
      bus(1'b1, `TPC_ADDR_CTRL, 32'h3);
      pkt(10, 0, -1, 2, 8'h40, 2'b10, 3);
      pkt(10, 0, 5, -1, 8'h50, 2'b01, 3);
      $display("test errors done");
   endtask
   task automatic t_modes;
      bus(1'b1, `TPC_ADDR_STATUS, 32'h3000_0000);
      bus(1'b1, `TPC_ADDR_CTRL, 32'h5);
      pkt(10, 0, -1, -1, 8'h60, 2'b00, 3);
      pkt(10, 0, -1, -1, 8'h61, 2'b00, 0);
      bus(1'b1, `TPC_ADDR_STATUS, 32'h3000_0000);
      pkt(10, 0, -1, -1, 8'h62, 2'b00, 3);
      bus(1'b1, `TPC_ADDR_STATUS, 32'h3000_0000);
      bus(1'b1, `TPC_ADDR_CTRL, 32'h1);
      pkt(10, 0, -1, -1, 8'h70, 2'b00, 3);
      pkt(10, 0, -1, -1, 8'h71, 2'b00, 3);
      pkt(10, 0, -1, -1, 8'h72, 2'b00, 0);
      bus(1'b1, `TPC_ADDR_STATUS, 32'h3000_0000);
      pkt(10, 0, -1, -1, 8'h73, 2'b00, 3);
      $display("test modes done");
   endtask
   task automatic t_time;
      bus(1'b1, `TPC_ADDR_STIME_LO, 32'h0);
      bus(1'b1, `TPC_ADDR_STIME_HI, 32'h012A_0000);
      repeat (60) @(posedge pclk);
      bus(1'b0, `TPC_ADDR_STIME_LO, 32'h0);
      `CHK(rd, 32'h1)
      bus(1'b1, `TPC_ADDR_CTRL, 32'h13);
      bus(1'b1, `TPC_ADDR_STIME_HI, 32'h0);
      repeat (60) @(posedge pclk);
      bus(1'b0, `TPC_ADDR_STIME_LO, 32'h0);
      `CHK(rd > 32'h4 && rd < 32'h10, 1'b1)
      // The stamp must be the time of the first byte, a few ticks after the read
      pkt(10, 0, -1, -1, 8'h80, 2'b00, 3);
      `CHK(q[2][32:0] - rd <= 33'h4, 1'b1)
      bus(1'b0, `TPC_ADDR_STIME_HI, 32'h0);
      `CHK(rd[24:16], 9'h000)
      bus(1'b1, `TPC_ADDR_CYCLE, 32'h4);
      bus(1'b1, `TPC_ADDR_CTRL, 32'h41);
      repeat (40) @(posedge pclk);
      `CHK(time_event, 1'b1)
      bus(1'b1, `TPC_ADDR_CTRL, 32'h1);
      bus(1'b1, `TPC_ADDR_STATUS, 32'h4000_0000);
      @(posedge pclk);
      `CHK(time_event, 1'b0)
      bus(1'b1, `TPC_ADDR_ALARM_HI, 32'h0005_0000);
      bus(1'b1, `TPC_ADDR_STIME_HI, 32'h0);
      bus(1'b1, `TPC_ADDR_CTRL, 32'h21);
      repeat (40) @(posedge pclk);
      `CHK(time_event, 1'b1)
      $display("test time done");
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Generous bound: the whole sequence needs well under a tenth of this
   initial begin
      #500000;
      errors++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_basic();
      t_err();
      t_modes();
      t_time();
      close_out();
   end
endmodule
